// *** include/tmu_pkg.sv ***
// Package with constants and carrier types for the timer control unit
// Behaviour
// - Three independent timers, each holding a sixteen-bit count.
// - First and second timers each have one input line and one output line.
// - Third timer has no line; time base, prescaler for others, DMA request source.
// - Each timer serviced once per four core cycles, limiting external counting.
// - Output responds to an input clock event within six core cycles.
// - Each timer has a maximum-count value and counts only up to it.
// - First and second timers have a second limit; dual mode alternates limits.
// - Pulse-width measurement times high and low phases of interrupt line two.
// - Inverted interrupt inputs interrupt on pin falling edge and are inputs only.
// - Core clock driving the timers runs at forty megahertz from the crystal.
// - Power-save keeps the timers running, but from a reduced clock rate.
// - Any interrupt in power-save restores the normal clock rate automatically.
package tmu_pkg;
    localparam int TMU_NUM_TIMERS = 3;
    localparam int TMU_CNT_W = 16;
    localparam int TMU_SLOTS = 4;
    localparam int TMU_CLK_MHZ = 100;
    localparam int TMU_CORE_MHZ = 40;
    localparam int TMU_OUT_RESP_CYC = 6;
    localparam int TMU_PS_DIV = 8;
    localparam int TMU_IRQ_W = 8;
    localparam logic [1:0] TMU_SLOT_RST = 2'h0;
    localparam logic [15:0] TMU_CNT_RST = 16'h0000;
    localparam logic [15:0] TMU_CNT_SAT = 16'hFFFF;

    // Per-timer configuration carried as one bundle
    typedef struct packed {
        logic en;
        logic dual;
        logic ext_clk;
        logic prescale;
        logic [15:0] max_a;
        logic [15:0] max_b;
    } tmu_tcfg_t;

    // Pulse-width measurement result
    typedef struct packed {
        logic [15:0] high_width;
        logic [15:0] low_width;
    } tmu_pw_res_t;

    typedef enum logic [1:0] {
        TMU_SLOT_T0 = 2'b00,
        TMU_SLOT_T1 = 2'b01,
        TMU_SLOT_T2 = 2'b10,
        TMU_SLOT_IDLE = 2'b11
    } tmu_slot_t;
endpackage

// *** rtl/tmu_top.sv ***
// Three-timer control unit with pulse-width measurement and power-save clock slowing
module tmu_top #(
    parameter int PS_DIV = tmu_pkg::TMU_PS_DIV
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Timer configuration, same clock domain
    input wire tmu_pkg::tmu_tcfg_t event_timer_first_cfg,
    input wire tmu_pkg::tmu_tcfg_t event_timer_second_cfg,
    input wire tmu_pkg::tmu_tcfg_t internal_prescale_timer_cfg,
    // Timer pins
    input wire logic event_timer_first_in,
    input wire logic event_timer_second_in,
    output logic event_timer_first_out,
    output logic event_timer_second_out,
    // Internal timer event toward DMA
    output logic dma_req,
    // Interrupt line two at the board pin, and other interrupt sources
    input wire logic ext_irq_line_two_pin,
    input wire logic [tmu_pkg::TMU_IRQ_W-1:0] other_irq,
    output logic ext_irq_line_two_irq,
    // Pulse-width measurement
    input wire logic pulse_width_measure_en,
    output tmu_pkg::tmu_pw_res_t pulse_width_measure_res,
    output logic pulse_width_measure_valid,
    // Power save
    input wire logic power_save_enter,
    output logic power_save_active
);
    import tmu_pkg::*;

    tmu_tcfg_t cfg [TMU_NUM_TIMERS];
    logic [15:0] cnt_q [TMU_NUM_TIMERS];
    logic [15:0] cnt_d [TMU_NUM_TIMERS];
    logic [TMU_NUM_TIMERS-1:0] sel_b_q, sel_b_d, out_q, out_d, pend_q, pend_d;
    logic dma_q, dma_d;
    logic [1:0] slot_q, slot_d;
    logic [7:0] ps_cnt_q, ps_cnt_d;
    logic ps_q, ps_d;
    logic tick;
    // Synchronisers: stage one feeds only stage two
    logic [2:0] sync1_q, sync2_q, prev_q;
    logic [2:0] ext_rise;
    logic irq_fall;
    logic [15:0] hi_cnt_q, hi_cnt_d, lo_cnt_q, lo_cnt_d;
    tmu_pw_res_t res_q, res_d;
    logic pwv_q, pwv_d, irq_q, irq_d;

    assign cfg[0] = event_timer_first_cfg;
    assign cfg[1] = event_timer_second_cfg;
    assign cfg[2] = internal_prescale_timer_cfg;

    // Saturating increment shared by both phase counters
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == TMU_CNT_SAT) ? v : v + 16'h0001;
    endfunction

    // Two-flop synchronisers; reset to idle pin levels so release shows no false edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 3'h4;
            sync2_q <= 3'h4;
            prev_q <= 3'h4;
        end else begin
            sync1_q <= {ext_irq_line_two_pin, event_timer_second_in, event_timer_first_in};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Rising input edges clock the pin timers; a pin fall raises the interrupt
    assign ext_rise = {1'b0, sync2_q[1:0] & ~prev_q[1:0]};
    assign irq_fall = prev_q[2] & ~sync2_q[2];

    // Power-save divider: slot advance only every PS_DIV cycles while slowed
    assign tick = !ps_q || (ps_cnt_q == 8'h00);

    always_comb begin
        ps_d = ps_q;
        ps_cnt_d = ps_cnt_q;
        if (irq_fall || (|other_irq)) begin
            ps_d = 1'b0;
        end else if (power_save_enter) begin
            ps_d = 1'b1;
        end
        if (!ps_q || ps_cnt_q == 8'(PS_DIV - 1)) begin
            ps_cnt_d = 8'h00;
        end else begin
            ps_cnt_d = ps_cnt_q + 8'h01;
        end
    end

    // Service slot: each timer gets one slot out of four
    always_comb begin
        slot_d = slot_q;
        if (tick) begin
            slot_d = slot_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ps_q <= 1'b0;
            ps_cnt_q <= 8'h00;
            slot_q <= TMU_SLOT_RST;
        end else begin
            ps_q <= ps_d;
            ps_cnt_q <= ps_cnt_d;
            slot_q <= slot_d;
        end
    end

    // Timer counting, limits and outputs
    always_comb begin
        logic svc;
        logic evt;
        logic [15:0] lim;
        svc = 1'b0;
        evt = 1'b0;
        lim = TMU_CNT_RST;
        sel_b_d = sel_b_q;
        out_d = out_q;
        pend_d = pend_q;
        dma_d = 1'b0;
        for (int i = 0; i < TMU_NUM_TIMERS; i++) begin
            cnt_d[i] = cnt_q[i];
        end
        for (int i = TMU_NUM_TIMERS - 1; i >= 0; i--) begin
            svc = tick && (slot_q == 2'(i));
            if (i < 2 && (cfg[i].ext_clk || cfg[i].prescale)) begin
                evt = pend_q[i];
            end else begin
                evt = 1'b1;
            end
            // Second limit only exists for the pin timers
            lim = (i < 2 && cfg[i].dual && sel_b_q[i]) ? cfg[i].max_b : cfg[i].max_a;
            if (svc) begin
                pend_d[i] = 1'b0;
            end
            if (svc && cfg[i].en && evt) begin
                if (cnt_q[i] >= lim) begin
                    cnt_d[i] = TMU_CNT_RST;
                    if (i < 2 && cfg[i].dual) begin
                        sel_b_d[i] = ~sel_b_q[i];
                        out_d[i] = sel_b_q[i];
                    end else begin
                        out_d[i] = 1'b0;
                    end
                    if (i == 2) begin
                        dma_d = 1'b1;
                        pend_d[0] = pend_d[0] | cfg[0].prescale;
                        pend_d[1] = pend_d[1] | cfg[1].prescale;
                    end
                end else begin
                    cnt_d[i] = cnt_q[i] + 16'h0001;
                    if (!(i < 2 && cfg[i].dual)) begin
                        out_d[i] = 1'b1;
                    end
                end
            end
            // New events arriving in a servicing cycle are kept
            if (i < 2 && cfg[i].ext_clk && !cfg[i].prescale) begin
                pend_d[i] = pend_d[i] | ext_rise[i];
            end
            if (!cfg[i].en) begin
                sel_b_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < TMU_NUM_TIMERS; i++) begin
                cnt_q[i] <= TMU_CNT_RST;
            end
            sel_b_q <= 3'h0;
            out_q <= 3'h7;
            pend_q <= 3'h0;
            dma_q <= 1'b0;
        end else begin
            for (int i = 0; i < TMU_NUM_TIMERS; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
            sel_b_q <= sel_b_d;
            out_q <= out_d;
            pend_q <= pend_d;
            dma_q <= dma_d;
        end
    end

    // Pulse-width measurement on the inverted interrupt line two
    always_comb begin
        hi_cnt_d = hi_cnt_q;
        lo_cnt_d = lo_cnt_q;
        res_d = res_q;
        pwv_d = 1'b0;
        irq_d = irq_fall;
        if (!pulse_width_measure_en) begin
            hi_cnt_d = TMU_CNT_RST;
            lo_cnt_d = TMU_CNT_RST;
        end else if (sync2_q[2] && !prev_q[2]) begin
            res_d.low_width = lo_cnt_q;
            lo_cnt_d = TMU_CNT_RST;
            hi_cnt_d = 16'h0001;
            pwv_d = 1'b1;
        end else if (irq_fall) begin
            res_d.high_width = hi_cnt_q;
            hi_cnt_d = TMU_CNT_RST;
            lo_cnt_d = 16'h0001;
            pwv_d = 1'b1;
        end else if (sync2_q[2]) begin
            hi_cnt_d = sat_inc(hi_cnt_q);
        end else begin
            lo_cnt_d = sat_inc(lo_cnt_q);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt_q <= TMU_CNT_RST;
            lo_cnt_q <= TMU_CNT_RST;
            res_q <= '0;
            pwv_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            hi_cnt_q <= hi_cnt_d;
            lo_cnt_q <= lo_cnt_d;
            res_q <= res_d;
            pwv_q <= pwv_d;
            irq_q <= irq_d;
        end
    end

    // Registered outputs
    assign event_timer_first_out = out_q[0];
    assign event_timer_second_out = out_q[1];
    assign dma_req = dma_q;
    assign ext_irq_line_two_irq = irq_q;
    assign pulse_width_measure_res = res_q;
    assign pulse_width_measure_valid = pwv_q;
    assign power_save_active = ps_q;
endmodule

// *** dv/tmu_props.sv ***
// Port checker for the timer unit
module tmu_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Watched ports
    input wire tmu_pkg::tmu_tcfg_t internal_prescale_timer_cfg,
    input wire logic event_timer_first_out,
    input wire logic dma_req,
    input wire logic ext_irq_line_two_pin,
    input wire logic [tmu_pkg::TMU_IRQ_W-1:0] other_irq,
    input wire logic ext_irq_line_two_irq,
    input wire tmu_pkg::tmu_pw_res_t pulse_width_measure_res,
    input wire logic pulse_width_measure_valid,
    input wire logic power_save_enter,
    input wire logic power_save_active
);
    timeunit 1ns;
    timeprecision 1ps;
    import tmu_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Pin fall and the pulse it must cause
    sequence s_fall;
        $fell(ext_irq_line_two_pin);
    endsequence
    sequence s_irq_soon;
        ##[2:5] ext_irq_line_two_irq;
    endsequence
    // Interrupt and width measurement
    a_irq_on_fall: assert property (s_fall |-> s_irq_soon)
        else $error("no interrupt after pin fall");
    a_irq_not_rise: assert property (
        ext_irq_line_two_irq |-> !$past(ext_irq_line_two_pin, 2))
        else $error("interrupt without pin fall");
    a_width_hold: assert property (
        !pulse_width_measure_valid |-> $stable(pulse_width_measure_res))
        else $error("width changed without valid");
    // Timer service pacing
    a_dma_spacing: assert property (dma_req |=> !dma_req [*3])
        else $error("dma pulses too close");
    a_dma_idle: assert property (!internal_prescale_timer_cfg.en [*8] |-> !dma_req)
        else $error("dma from stopped timer");
    a_out_stands: assert property (
        $changed(event_timer_first_out) |=> $stable(event_timer_first_out) [*3])
        else $error("output changed within a service period");
    // Power save entry and wake
    // A pin fall reaches the wake logic from the second synchroniser stage
    a_ps_enter: assert property (power_save_enter && !(|other_irq) &&
        ext_irq_line_two_pin && $past(ext_irq_line_two_pin, 2) |=> power_save_active)
        else $error("power save not entered");
    a_ps_wake: assert property (power_save_active && |other_irq |=> !power_save_active)
        else $error("no wake on interrupt");
endmodule

bind tmu_top tmu_props u_tmu_props (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .internal_prescale_timer_cfg(internal_prescale_timer_cfg),
    .event_timer_first_out(event_timer_first_out),
    .dma_req(dma_req),
    .ext_irq_line_two_pin(ext_irq_line_two_pin),
    .other_irq(other_irq),
    .ext_irq_line_two_irq(ext_irq_line_two_irq),
    .pulse_width_measure_res(pulse_width_measure_res),
    .pulse_width_measure_valid(pulse_width_measure_valid),
    .power_save_enter(power_save_enter),
    .power_save_active(power_save_active)
);

// *** dv/tmu_ext_model.sv ***
// Model of the external event source and output load
module tmu_ext_model (
    // Clock and pacing
    input wire logic ref_clk,
    input wire logic [7:0] half_period,
    // Timer pins
    input wire logic out_first,
    output logic in_first,
    output logic [15:0] out_falls
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q = 8'h00;
    logic in_q = 1'b0;
    logic [15:0] falls_q = 16'h0000;
    // Square wave on the input pin, held low while pacing is zero
    always @(posedge ref_clk) begin
        cnt_q <= (cnt_q >= half_period) ? 8'h00 : cnt_q + 8'h01;
        if (half_period == 8'h00) in_q <= 1'b0;
        else if (cnt_q == half_period) in_q <= !in_q;
    end
    // Load counts falling edges of the output
    always @(negedge out_first) falls_q <= falls_q + 16'h0001;
    // Single driver for each port
    assign in_first = in_q;
    assign out_falls = falls_q;
endmodule

// *** dv/tmu_top_tb_top.sv ***
// Self-checking bench for the timer unit
module tmu_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tmu_pkg::*;
    logic ref_clk = 1'b0, arst_n = 1'b0;
    tmu_tcfg_t cfg0 = '0, cfg1 = '0, cfg2 = '0;
    logic in1, in2, pin = 1'b1, pen = 1'b0, pse = 1'b0, o1p = 1'b1;
    logic [7:0] oirq = 8'h00, half = 8'h00;
    logic out0, out1, dma, irq, vld, psa;
    logic [15:0] falls, falls2, m, f, f2;
    tmu_pw_res_t res;
    int failures = 0, comparisons = 0, seed = 75345, irqs = 0, w, h;
    int qd[$], qo[$], qp[$];
    time td = 0, tr = 0, t0 = 0;
    always #5 ref_clk = !ref_clk;
    tmu_top #(.PS_DIV(2)) u_tmu_top (.ref_clk(ref_clk), .arst_n(arst_n),
        .event_timer_first_cfg(cfg0), .event_timer_second_cfg(cfg1),
        .internal_prescale_timer_cfg(cfg2), .event_timer_first_in(in1),
        .event_timer_second_in(in2), .event_timer_first_out(out0),
        .event_timer_second_out(out1), .dma_req(dma), .ext_irq_line_two_pin(pin),
        .other_irq(oirq), .ext_irq_line_two_irq(irq), .pulse_width_measure_en(pen),
        .pulse_width_measure_res(res), .pulse_width_measure_valid(vld),
        .power_save_enter(pse), .power_save_active(psa));
    tmu_ext_model u_tmu_ext_model (.ref_clk(ref_clk), .half_period(half),
        .out_first(out0), .in_first(in1), .out_falls(falls));
    // Same source and load on the second pin timer
    tmu_ext_model u_tmu_ext_model_b (.ref_clk(ref_clk), .half_period(half),
        .out_first(out1), .in_first(in2), .out_falls(falls2));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Wait until every note is consumed, bounded
    task automatic fin(input int n);
        for (int i = 0; i < 3000 && qd.size() + qo.size() + qp.size() > 0; i++) cyc(1);
        if (qd.size() + qo.size() + qp.size() > 0) begin
            failures++;
            $display("Error at %0t: test %0d timed out", $time, n);
            close_out();
        end else begin
            $display("Test %0d done", n);
        end
    endtask
    // Watchers: each observed event consumes the oldest note and is compared with it unless the note is -1
    always @(posedge ref_clk) begin
        if (dma === 1'b1 && qd.size() > 0) begin
            if (qd[0] >= 0) check(16'(($time - td) / 10), 16'(qd[0]));
            void'(qd.pop_front());
        end
        if (dma === 1'b1) td = $time;
        if (out1 !== o1p && out1 === 1'b1) tr = $time;
        if (out1 !== o1p && out1 === 1'b0 && qo.size() > 0) begin
            if (qo[0] >= 0) check(16'(($time - tr) / 10), 16'(qo[0]));
            void'(qo.pop_front());
        end
        o1p = out1;
        if (vld === 1'b1 && qp.size() > 0) begin
            if (qp[0] >= 0) check(pin ? res.low_width : res.high_width, 16'(qp[0]));
            void'(qp.pop_front());
        end
        if (irq === 1'b1) irqs++;
    end
    // Main sequence
    initial begin
        cyc(8);
        arst_n <= 1'b1;
        cyc(2);
        check({11'h000, out0, out1, dma, vld, psa}, 16'h0018);
        for (int i = 0; i < 3; i++) begin
            m = (i == 2) ? 16'h0002 : 16'(1 + $unsigned($random(seed)) % 6);
            cfg2 <= '{1'b1, 1'b0, 1'b0, 1'b0, m, 16'h0000};
            qd = '{-1, -1, 4 * (m + 1), 4 * (m + 1)};
            fin(1);
        end
        pse <= 1'b1;
        cyc(1);
        pse <= 1'b0;
        qd = '{-1, -1, 24, 24};
        fin(2);
        check({15'h0000, psa}, 16'h0001);
        oirq <= 8'h04;
        cyc(1);
        oirq <= 8'h00;
        cyc(1);
        check({15'h0000, psa}, 16'h0000);
        cfg1 <= '{1'b1, 1'b1, 1'b0, 1'b0, 16'h0003, 16'h0001};
        qo = '{-1, 16, 16};
        fin(3);
        // Both pin timers count external rises
        cfg0 <= '{1'b1, 1'b0, 1'b1, 1'b0, 16'h0002, 16'h0000};
        cfg1 <= '{1'b1, 1'b0, 1'b1, 1'b0, 16'h0002, 16'h0000};
        half <= 8'h07;
        f = falls;
        f2 = falls2;
        cyc(640);
        check(16'(falls - f >= 10 && falls - f <= 20), 16'h0001);
        check(16'(falls2 - f2 >= 10 && falls2 - f2 <= 20), 16'h0001);
        // No events and a stopped third timer leave everything still
        half <= 8'h00;
        cfg2.en <= 1'b0;
        cyc(20);
        f = falls;
        f2 = falls2;
        t0 = td;
        cyc(100);
        check(falls, f);
        check(falls2, f2);
        check(16'(td != t0), 16'h0000);
        pen <= 1'b1;
        cyc(5);
        for (int i = 0; i < 4; i++) begin
            w = 8 + $unsigned($random(seed)) % 32;
            pin <= 1'b0;
            qp.push_back(i == 0 ? -1 : h);
            cyc(w);
            pin <= 1'b1;
            qp.push_back(w);
            h = 8 + $unsigned($random(seed)) % 32;
            cyc(h);
        end
        fin(4);
        check(16'(irqs), 16'h0004);
        close_out();
    end
endmodule
